/* pwr_mode_pkg.sv */
package pwr_mode_pkg;

  // ************************************************************
  // Register map, byte addresses on the APB bus.
  // ************************************************************
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] wake_cfg_off = 8'h04;
  localparam logic [7:0] io_pull_up_off = 8'h08;
  localparam logic [7:0] io_pull_dn_off = 8'h0c;
  localparam logic [7:0] status_off = 8'h10;

  // ************************************************************
  // Field positions of the control register.
  // ************************************************************
  localparam int ctrl_mode_lsb = 0;
  localparam int ctrl_req_bit = 3;
  localparam int ctrl_ret_bit = 4;
  localparam int ctrl_rtc_bit = 5;
  localparam int ctrl_clk_bit = 6;
  localparam int ctrl_radio_bit = 7;

  // ************************************************************
  // Reset values.
  // ************************************************************
  localparam logic [7:0] ctrl_rst = 8'h00;
  localparam logic [1:0] wake_cfg_rst = 2'h0;

  // Requested mode codes written by software.
  localparam logic [2:0] req_run = 3'h0;
  localparam logic [2:0] req_lprun = 3'h1;
  localparam logic [2:0] req_stop0 = 3'h2;
  localparam logic [2:0] req_stop1 = 3'h3;
  localparam logic [2:0] req_standby = 3'h4;
  localparam logic [2:0] req_shutdown = 3'h5;
  localparam logic [2:0] req_sleep = 3'h6;

  // Radio requested depth: 0 run, 1 stop, 2 standby.
  localparam logic [1:0] radio_run = 2'h0;
  localparam logic [1:0] radio_stop = 2'h1;
  localparam logic [1:0] radio_standby = 2'h2;

  // System clock selection codes after wake-up.
  localparam logic [1:0] clk_msi_4m = 2'h0;
  localparam logic [1:0] clk_hsi_16m = 2'h1;
  localparam logic [1:0] clk_msi_sel = 2'h2;

  // Power modes, one-hot.
  typedef enum logic [7:0] {
    st_run = 8'h01,
    st_sleep = 8'h02,
    st_lprun = 8'h04,
    st_lpsleep = 8'h08,
    st_stop0 = 8'h10,
    st_stop1 = 8'h20,
    st_standby = 8'h40,
    st_shutdown = 8'h80
  } pwr_mode_e;

endpackage : pwr_mode_pkg

/* low_power_mode_controller.sv */
// Notes on behaviour
// RULE1 - Reset lands in Run; low-power only on request.
// RULE2 - Sleep halts application core; any interrupt wakes.
// RULE3 - Low-power run: low regulator, slow clock, radio off.
// RULE4 - Low-power sleep only from low-power run, returns there.
// RULE5 - Stop keeps SRAM, registers, low-speed clocks; RTC optional.
// RULE6 - Stop 0 keeps main regulator; Stop 1 drops it.
// RULE7 - Stop exit clock multispeed or 16 MHz; radio forces 16 MHz.
// RULE8 - Wake-capable peripherals may enable fast oscillator in Stop.
// RULE9 - Standby removes core supply; brownout reset stays.
// RULE10 - Standby may retain SRAM on low regulator.
// RULE11 - Standby I/O pull-up, pull-down or float per pin.
// RULE12 - Standby wake sources: reset, watchdog, pin, RTC, crystal failure.
// RULE13 - Standby wake restarts on 16 MHz oscillator.
// RULE14 - Standby and Shutdown refused while radio needed.
// RULE15 - Shutdown disables brownout reset and supply monitors.
// RULE16 - Shutdown loses all SRAM banks and registers.
// RULE17 - Shutdown wake: reset pin, wake pin, RTC only.
// RULE18 - Shutdown wake restarts on 4 MHz multispeed oscillator.
// RULE19 - Effective state is shallower of core and radio requests.
// RULE20 - Brownout bypass forced through Stop 0, not deeper.
// RULE21 - Illegal transitions are ignored; mode holds.
`timescale 1ns/1ps
module low_power_mode_controller
  import pwr_mode_pkg::*;
#(
  parameter int io_count = 16
) (
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Radio core power request.
  input wire logic [1:0] radio_core_req,
  // Wake and exit events.
  input wire logic core_irq,
  input wire logic external_reset_pin,
  input wire logic independent_watchdog_rst,
  input wire logic wakeup_pin,
  input wire logic rtc_event,
  input wire logic clock_failure_detector_lse,
  input wire logic periph_hsi_req,
  // Power and clock controls.
  output logic application_core_halt,
  output logic main_regulator_on,
  output logic low_power_regulator_on,
  output logic core_supply_domain_on,
  output logic radio_core_enable,
  output logic sram_bank_one_on,
  output logic sram_bank_two_lower_on,
  output logic sram_bank_two_upper_on,
  output logic regs_retained,
  output logic low_speed_clocks_on,
  output logic rtc_on,
  output logic fast_internal_rc_osc_on,
  output logic core_clk_limit_2m,
  output logic [1:0] sys_clk_sel,
  output logic brownout_reset_on,
  output logic supply_level_detector_on,
  output logic analog_supply_monitor_on,
  output logic brownout_bypass_on,
  output logic [io_count-1:0] io_pull_up,
  output logic [io_count-1:0] io_pull_down,
  output logic [7:0] mode_state
);

  // ************************************************************
  // State.
  // ************************************************************
  typedef struct packed {
    pwr_mode_e mode;
    logic [7:0] ctrl;
    logic [1:0] wake_cfg;
    logic [io_count-1:0] pu;
    logic [io_count-1:0] pd;
    logic wkp_prev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [17:0] outs;
    logic [1:0] clk;
    logic [io_count-1:0] pu_o;
    logic [io_count-1:0] pd_o;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // Depth of a mode, used to pick the shallower of two requests.
  function automatic logic [2:0] depth(input pwr_mode_e m);
    case (m)
      st_run, st_sleep: depth = 3'h0;
      st_lprun, st_lpsleep: depth = 3'h1;
      st_stop0: depth = 3'h2;
      st_stop1: depth = 3'h3;
      st_standby: depth = 3'h4;
      st_shutdown: depth = 3'h5;
      default: depth = 3'h0;
    endcase
  endfunction : depth

  // Combinational next state.
  always_comb begin
    pwr_mode_e want;
    pwr_mode_e radio_m;
    logic radio_need;
    logic wk_edge;
    logic acc;
    want = st_r.mode;
    radio_m = st_run;
    radio_need = 1'b0;
    wk_edge = 1'b0;
    acc = 1'b0;
    st_nxt = st_r;
    acc = psel && penable && !st_r.pready;
    // Bus answers one cycle into the access phase.
    st_nxt.pready = acc;
    st_nxt.pslverr = 1'b0;
    if (acc) begin
      st_nxt.pslverr = !(paddr == ctrl_off || paddr == wake_cfg_off || paddr == io_pull_up_off ||
                         paddr == io_pull_dn_off || paddr == status_off);
      st_nxt.prdata = 32'h0;
      if (pwrite) begin
        case (paddr)
          ctrl_off: st_nxt.ctrl = pwdata[7:0];
          wake_cfg_off: st_nxt.wake_cfg = pwdata[1:0];
          io_pull_up_off: st_nxt.pu = pwdata[io_count-1:0]; // RULE11
          io_pull_dn_off: st_nxt.pd = pwdata[io_count-1:0]; // RULE11
          default: ;
        endcase
      end else begin
        case (paddr)
          ctrl_off: st_nxt.prdata = {24'h0, st_r.ctrl};
          wake_cfg_off: st_nxt.prdata = {30'h0, st_r.wake_cfg};
          io_pull_up_off: st_nxt.prdata[io_count-1:0] = st_r.pu;
          io_pull_dn_off: st_nxt.prdata[io_count-1:0] = st_r.pd;
          status_off: st_nxt.prdata = {22'h0, st_r.clk, st_r.mode};
          default: ;
        endcase
      end
    end
    // Radio request decode; radio needed when the control radio bit is set and it asks run or stop.
    radio_need = st_r.ctrl[ctrl_radio_bit] && radio_core_req != radio_standby;
    if (radio_core_req == radio_stop) begin
      radio_m = st_stop1;
    end else if (radio_core_req == radio_standby) begin
      radio_m = st_standby;
    end
    wk_edge = (wakeup_pin ^ st_r.wkp_prev) && (wakeup_pin == !st_r.wake_cfg[0]);
    st_nxt.wkp_prev = wakeup_pin;
    // Software request, taken once and self-cleared.
    if (st_r.ctrl[ctrl_req_bit]) begin
      st_nxt.ctrl[ctrl_req_bit] = 1'b0;
      case (st_r.ctrl[ctrl_mode_lsb +: 3])
        req_run: want = st_run; // RULE1
        req_sleep: want = (st_r.mode == st_run) ? st_sleep : st_r.mode; // RULE21
        req_lprun: begin
          if (st_r.mode == st_lprun && !radio_need) begin
            want = st_lpsleep; // RULE4
          end else if (st_r.mode == st_run && !radio_need) begin
            want = st_lprun; // RULE3
          end
        end
        req_stop0: want = (depth(st_r.mode) <= 3'h1) ? st_stop0 : st_r.mode; // RULE21
        req_stop1: want = (depth(st_r.mode) <= 3'h1) ? st_stop1 : st_r.mode;
        req_standby: if (!radio_need && depth(st_r.mode) <= 3'h1) want = st_standby; // RULE14
        req_shutdown: if (!radio_need && depth(st_r.mode) <= 3'h1) want = st_shutdown; // RULE14
        default: ;
      endcase
    end
    // Radio may hold the system shallower than software asked.
    if (st_r.ctrl[ctrl_radio_bit] && depth(want) > depth(radio_m) && depth(want) >= 3'h2) begin
      want = (radio_m == st_run) ? st_run : radio_m; // RULE19
    end
    // Wake-up handling per mode.
    case (st_r.mode)
      st_sleep: if (core_irq) want = st_run; // RULE2
      st_lpsleep: if (core_irq) want = st_lprun; // RULE4
      st_stop0, st_stop1: begin
        if (core_irq || wk_edge || rtc_event) begin
          want = st_run;
          st_nxt.clk = (radio_need || st_r.ctrl[ctrl_clk_bit]) ? clk_hsi_16m : clk_msi_sel; // RULE7
        end
      end
      st_standby: begin
        if (external_reset_pin || independent_watchdog_rst || wk_edge || rtc_event ||
            clock_failure_detector_lse) begin // RULE12
          want = st_run;
          st_nxt.clk = clk_hsi_16m; // RULE13
          st_nxt.ctrl = ctrl_rst; // RULE9
          st_nxt.wake_cfg = wake_cfg_rst;
        end
      end
      st_shutdown: begin
        if (external_reset_pin || wk_edge || rtc_event) begin // RULE17
          want = st_run;
          st_nxt.clk = clk_msi_4m; // RULE18
          st_nxt.ctrl = ctrl_rst; // RULE16
          st_nxt.wake_cfg = wake_cfg_rst;
          st_nxt.pu = '0;
          st_nxt.pd = '0;
        end
      end
      default: ;
    endcase
    st_nxt.mode = want;
    // Output decode from the next mode.
    st_nxt.outs[0] = !(want == st_run || want == st_lprun); // RULE2
    st_nxt.outs[1] = want == st_run || want == st_sleep || want == st_stop0; // RULE6
    st_nxt.outs[2] = want == st_lprun || want == st_lpsleep || want == st_stop1 ||
                     (want == st_standby && st_nxt.ctrl[ctrl_ret_bit]); // RULE3 RULE10
    st_nxt.outs[3] = depth(want) <= 3'h3; // RULE9
    st_nxt.outs[4] = !(want == st_lprun || want == st_lpsleep || want == st_shutdown); // RULE3
    st_nxt.outs[5] = depth(want) <= 3'h3 || (want == st_standby && st_nxt.ctrl[ctrl_ret_bit]); // RULE10
    st_nxt.outs[6] = depth(want) <= 3'h3; // RULE5 RULE16
    st_nxt.outs[7] = want != st_shutdown; // RULE5
    st_nxt.outs[8] = depth(want) <= 3'h1 || st_nxt.ctrl[ctrl_rtc_bit]; // RULE5
    st_nxt.outs[9] = depth(want) <= 3'h1 ||
                     ((want == st_stop0 || want == st_stop1) && periph_hsi_req); // RULE8
    st_nxt.outs[10] = want == st_lprun || want == st_lpsleep; // RULE3
    st_nxt.outs[11] = want != st_shutdown; // RULE9 RULE15
    st_nxt.outs[12] = depth(want) <= 3'h3; // RULE15
    st_nxt.outs[13] = depth(want) <= 3'h2; // RULE20
    st_nxt.outs[14] = want == st_standby; // RULE11
    // Pull selections reach the pins only in Standby, from their own flops.
    st_nxt.pu_o = (want == st_standby) ? st_nxt.pu : '0; // RULE11
    st_nxt.pd_o = (want == st_standby) ? st_nxt.pd : '0; // RULE11
  end

  // Register the whole state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{mode: st_run, ctrl: ctrl_rst, wake_cfg: wake_cfg_rst, pu: '0, pd: '0, wkp_prev: 1'b0,
                prdata: 32'h0, pready: 1'b0, pslverr: 1'b0, outs: 18'h0_3bfa, clk: clk_msi_4m,
                pu_o: '0, pd_o: '0}; // RULE1
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // Outputs, all straight from state flip-flops.
  // ************************************************************
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign application_core_halt = st_r.outs[0];
  assign main_regulator_on = st_r.outs[1];
  assign low_power_regulator_on = st_r.outs[2];
  assign core_supply_domain_on = st_r.outs[3];
  assign radio_core_enable = st_r.outs[4];
  assign sram_bank_one_on = st_r.outs[5];
  assign sram_bank_two_lower_on = st_r.outs[5];
  assign sram_bank_two_upper_on = st_r.outs[5];
  assign regs_retained = st_r.outs[6];
  assign low_speed_clocks_on = st_r.outs[7];
  assign rtc_on = st_r.outs[8];
  assign fast_internal_rc_osc_on = st_r.outs[9];
  assign core_clk_limit_2m = st_r.outs[10];
  assign brownout_reset_on = st_r.outs[11];
  assign supply_level_detector_on = st_r.outs[12];
  assign analog_supply_monitor_on = st_r.outs[12];
  assign brownout_bypass_on = st_r.outs[13];
  assign io_pull_up = st_r.pu_o;
  assign io_pull_down = st_r.pd_o;
  assign sys_clk_sel = st_r.clk;
  assign mode_state = st_r.mode;

endmodule : low_power_mode_controller

/* pwr_chk_assertions.sv */
`timescale 1ns/1ps
module pwr_chk
  import pwr_mode_pkg::*;
(
  // Clock, reset and watched outputs.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic application_core_halt,
  input wire logic main_regulator_on,
  input wire logic core_supply_domain_on,
  input wire logic radio_core_enable,
  input wire logic core_clk_limit_2m,
  input wire logic [1:0] sys_clk_sel,
  input wire logic brownout_reset_on,
  input wire logic brownout_bypass_on,
  input wire logic [7:0] mode_state
);
  // ****************
  // Mode properties.
  // ****************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  one_hot_a: assert property ($onehot(mode_state)) else $error("mode not one-hot");
  sleep_halt_a: assert property (mode_state == st_sleep |-> application_core_halt) else $error("sleep no halt");
  lprun_slow_a: assert property (mode_state == st_lprun |-> core_clk_limit_2m && !radio_core_enable)
    else $error("lprun limits");
  lpsleep_entry_a: assert property (mode_state == st_lpsleep |-> $past(mode_state) inside {st_lprun, st_lpsleep})
    else $error("lpsleep entry");
  stop0_reg_a: assert property (mode_state == st_stop0 |-> main_regulator_on) else $error("stop0 regulator");
  standby_off_a: assert property (mode_state == st_standby |-> !core_supply_domain_on && brownout_reset_on)
    else $error("standby supply");
  standby_clk_a: assert property ($past(mode_state) == st_standby && mode_state == st_run |-> sys_clk_sel == clk_hsi_16m)
    else $error("standby exit clock");
  shut_clk_a: assert property ($past(mode_state) == st_shutdown && mode_state == st_run |-> sys_clk_sel == clk_msi_4m)
    else $error("shutdown exit clock");
  shut_bor_a: assert property (brownout_reset_on == (mode_state != st_shutdown)) else $error("brownout state");
  bypass_map_a: assert property (brownout_bypass_on == (mode_state inside {st_run, st_sleep, st_lprun, st_lpsleep,
    st_stop0})) else $error("bypass state");
  cover property (mode_state == st_lpsleep);
  cover property (mode_state == st_standby);
  cover property (mode_state == st_shutdown);
endmodule : pwr_chk

bind low_power_mode_controller pwr_chk chk (.pclk, .presetn, .application_core_halt, .main_regulator_on,
  .core_supply_domain_on, .radio_core_enable, .core_clk_limit_2m, .sys_clk_sel, .brownout_reset_on,
  .brownout_bypass_on, .mode_state);

/* radio_model.sv */
`timescale 1ns/1ps
module radio_model
  import pwr_mode_pkg::*;
(
  // Clock, reset and bench command.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] want,
  // Controller side.
  input wire logic radio_core_enable,
  output logic [1:0] radio_core_req
);
  // The radio reports idle whenever it is switched off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      radio_core_req <= radio_standby;
    end else begin
      radio_core_req <= radio_core_enable ? want : radio_standby;
    end
  end
endmodule : radio_model

/* testbench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module testbench
  import pwr_mode_pkg::*;
;
  // ************
  // Bench state.
  // ************
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wakeup_pin = 0, periph_hsi_req = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, seed = 32'd17963;
  logic [4:0] ev = 0;
  logic [1:0] want = radio_run, radio_core_req, sys_clk_sel;
  logic pready, pslverr, application_core_halt, main_regulator_on, core_supply_domain_on, radio_core_enable;
  logic regs_retained, low_speed_clocks_on, core_clk_limit_2m, brownout_reset_on, brownout_bypass_on, serr;
  logic [15:0] io_pull_up;
  logic [7:0] mode_state;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  // Clock generation at 20 MHz.
  always #25 pclk = ~pclk;
  radio_model radio (.pclk, .presetn, .want, .radio_core_enable, .radio_core_req);
  low_power_mode_controller #(.io_count(16)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .radio_core_req, .core_irq(ev[0]), .external_reset_pin(ev[1]),
    .independent_watchdog_rst(ev[2]), .wakeup_pin, .rtc_event(ev[3]), .clock_failure_detector_lse(ev[4]),
    .periph_hsi_req, .application_core_halt, .main_regulator_on, .low_power_regulator_on(),
    .core_supply_domain_on, .radio_core_enable, .sram_bank_one_on(), .sram_bank_two_lower_on(),
    .sram_bank_two_upper_on(), .regs_retained, .low_speed_clocks_on, .rtc_on(), .fast_internal_rc_osc_on(),
    .core_clk_limit_2m, .sys_clk_sel, .brownout_reset_on, .supply_level_detector_on(),
    .analog_supply_monitor_on(), .brownout_bypass_on, .io_pull_up, .io_pull_down(), .mode_state);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic exp_bypass(input logic [7:0] m);
    return m inside {st_run, st_sleep, st_lprun, st_lpsleep, st_stop0};
  endfunction : exp_bypass
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  // One APB transfer; the request is held until pready is seen.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  // Waits a bounded time for the expected mode, then compares.
  task automatic wait_mode(input logic [7:0] e);
    repeat (3) @(posedge pclk);
    repeat (8) if (mode_state !== e) @(posedge pclk);
    `CHK(mode_state, e)
  endtask : wait_mode
  task automatic go(input logic [7:0] c, input logic [7:0] e);
    apb(1, ctrl_off, {24'h0, c});
    wait_mode(e);
  endtask : go
  task automatic pulse(input int i, input logic [7:0] e);
    ev <= 5'h01 << i;
    repeat (2) @(posedge pclk);
    ev <= 0;
    wait_mode(e);
  endtask : pulse
  // Cuts a hang short.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // Main sequence.
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    `CHK(mode_state, st_run)
    apb(0, 8'h14, 0);
    `CHK({serr, rd}, 33'h100000000)
    repeat (3) begin
      seed = xs(seed);
      apb(1, io_pull_up_off, seed);
      apb(0, io_pull_up_off, 0);
      `CHK(rd[15:0], seed[15:0])
    end
    $display("test registers done");
    go(8'h0e, st_sleep);
    `CHK(application_core_halt, 1'b1)
    pulse(0, st_run);
    go(8'h09, st_lprun);
    `CHK({core_clk_limit_2m, radio_core_enable}, 2'b10)
    go(8'h0e, st_lprun);
    go(8'h09, st_lpsleep);
    pulse(0, st_lprun);
    go(8'h08, st_run);
    $display("test sleep done");
    for (int c = 2; c < 4; c++) begin
      go(8'h08 | c, c == 2 ? st_stop0 : st_stop1);
      `CHK(main_regulator_on, c == 2)
      `CHK(brownout_bypass_on, exp_bypass(c == 2 ? st_stop0 : st_stop1))
      `CHK({regs_retained, low_speed_clocks_on}, 2'b11)
      pulse(3, st_run);
      `CHK(sys_clk_sel, clk_msi_sel)
    end
    go(8'h0c, st_standby);
    `CHK({core_supply_domain_on, brownout_reset_on}, 2'b01)
    `CHK(io_pull_up, seed[15:0])
    pulse(2, st_run);
    `CHK(sys_clk_sel, clk_hsi_16m)
    go(8'h0c, st_standby);
    wakeup_pin <= 1;
    wait_mode(st_run);
    go(8'h0d, st_shutdown);
    `CHK(brownout_reset_on, 1'b0)
    `CHK(regs_retained, 1'b0)
    pulse(2, st_shutdown);
    pulse(3, st_run);
    `CHK(sys_clk_sel, clk_msi_4m)
    $display("test deep modes done");
    go(8'h8a, st_run);
    go(8'h8c, st_run);
    $display("test radio done");
    give_verdict();
  end
endmodule : testbench
